// ===== fuse_config_and_parallel_prog_port_test.sv
/* self-checking bench for the fuse store and programming port.
   assumes the programmer model drives every strobe and the bus. */
`timescale 1ns/1ps
`default_nettype none
`define CHECK(got, exp) \
	begin \
		n_tests++; \
		if ((got) !== (exp)) begin \
			fail_count++; \
			$display("mismatch at %0t: got %h want %h", $time, got, exp); \
		end \
	end
module fuse_config_and_parallel_prog_port_test
	import fuse_prog_pkg::*;
;
	logic        clock_i = 1'b0;
	logic        rstn_i = 1'b0;
	logic        prog_mode_i = 1'b0;
	logic        serial_mode_i = 1'b0;
	logic        clk_pin, bs1, bs2, page_load_strobe, wr_n, oe_n, data_oe_o, ready_busy_out_o;
	logic [1:0]  act;
	logic [7:0]  bus, data_o, fuse_high_o, fuse_low_o, osc_calibration_reg_o;
	logic        eeprom_retain_fuse_o, erase_flash_o, erase_eeprom_o;
	logic        flash_page_write_o, eeprom_page_write_o, page_latch_o;
	logic [15:0] word_addr_o, page_data_o;
	int          fail_count = 0;
	int          n_tests = 0;
	int          n_ef = 0, n_ee = 0, n_fw = 0, n_pl = 0, n_ew = 0;
	logic [15:0] flash_rdata = 16'h0000;
	logic [7:0]  eeprom_rdata = 8'h00;

	always #20 clock_i = ~clock_i;
	always @(posedge clock_i) begin
		n_ef += (erase_flash_o === 1'b1);
		n_ee += (erase_eeprom_o === 1'b1);
		n_fw += (flash_page_write_o === 1'b1);
		n_pl += (page_latch_o === 1'b1);
		n_ew += (eeprom_page_write_o === 1'b1);
	end

	prog_model pm (.clock_i(clock_i), .data_o(data_o), .data_oe_o(data_oe_o),
		.clk_pin_o(clk_pin), .act_o(act), .bs1_o(bs1), .bs2_o(bs2), .page_load_strobe_o(page_load_strobe),
		.wr_n_o(wr_n), .oe_n_o(oe_n), .bus_o(bus));
	fuse_prog_port dut (.clock_i(clock_i), .rstn_i(rstn_i), .prog_mode_i(prog_mode_i),
		.serial_mode_i(serial_mode_i), .prog_clock_pin_i(clk_pin),
		.action_select_0_i(act[0]), .action_select_1_i(act[1]),
		.byte_select_first_i(bs1), .byte_select_second_i(bs2),
		.page_load_strobe_i(page_load_strobe), .write_n_i(wr_n), .output_enable_n_i(oe_n),
		.data_i(bus), .flash_rdata_i(flash_rdata), .eeprom_rdata_i(eeprom_rdata),
		.data_o(data_o), .data_oe_o(data_oe_o), .ready_busy_out_o(ready_busy_out_o),
		.fuse_high_o(fuse_high_o), .fuse_low_o(fuse_low_o),
		.eeprom_retain_fuse_o(eeprom_retain_fuse_o),
		.osc_calibration_reg_o(osc_calibration_reg_o), .erase_flash_o(erase_flash_o),
		.erase_eeprom_o(erase_eeprom_o), .flash_page_write_o(flash_page_write_o),
		.eeprom_page_write_o(eeprom_page_write_o), .page_latch_o(page_latch_o),
		.word_addr_o(word_addr_o), .page_data_o(page_data_o));

	task automatic end_sim;
		$display("counts: %0d compares, %0d mismatches", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : end_sim

	task automatic wait_ready;
		int n = 0;
		while (ready_busy_out_o !== 1'b1 && n < 40) begin
			pm.step(1);
			n++;
		end
		`CHECK(ready_busy_out_o, 1'b1)
	endtask : wait_ready

	task automatic mode(input logic on);
		prog_mode_i = on;
		pm.step(5);
	endtask : mode

	task automatic op(input logic [7:0] c, input logic b1, input logic [7:0] d);
		pm.load(ACT_CMD, 1'b0, c);
		pm.load(ACT_DATA, 1'b0, d);
		// byte select picks the target byte at the write strobe
		pm.select(b1);
		pm.pulse(2);
		wait_ready();
		pm.select(1'b0);
	endtask : op

	task automatic rd(input logic [7:0] c, input logic b1, input logic b2,
		output logic [7:0] v);
		pm.load(ACT_CMD, 1'b0, c);
		pm.read(b1, b2, v);
	endtask : rd

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset;
		`CHECK(fuse_high_o, 8'h99)
		`CHECK(fuse_low_o, 8'hE1)
		`CHECK(osc_calibration_reg_o, CAL_1MHZ)
		`CHECK(ready_busy_out_o, 1'b1)
		`CHECK(data_oe_o, 1'b0)
		$display("test reset done");
	endtask : t_reset

	task automatic t_sig;
		logic [7:0] sig [3] = '{SIG_BYTE0, SIG_BYTE1, SIG_BYTE2};
		logic [7:0] cal [4] = '{CAL_1MHZ, CAL_2MHZ, CAL_4MHZ, CAL_8MHZ};
		logic [7:0] v;
		for (int i = 0; i < 4; i++) begin
			pm.load(ACT_ADDR, 1'b0, 8'(i));
			rd(CMD_RD_SIG, 1'b1, 1'b0, v);
			`CHECK(v, cal[i])
			if (i < 3) begin
				rd(CMD_RD_SIG, 1'b0, 1'b0, v);
				`CHECK(v, sig[i])
			end
		end
		$display("test signature done");
	endtask : t_sig

	task automatic t_page;
		int fw = n_fw;
		pm.load(ACT_CMD, 1'b0, CMD_WR_FLASH);
		pm.load(ACT_ADDR, 1'b0, 8'h85);
		pm.load(ACT_ADDR, 1'b1, 8'h01);
		pm.load(ACT_DATA, 1'b0, 8'h34);
		pm.load(ACT_DATA, 1'b1, 8'h12);
		pm.load(ACT_IDLE, 1'b1, 8'h77);
		pm.pulse(1);
		`CHECK(n_pl, 1)
		`CHECK(word_addr_o, 16'h0185)
		`CHECK(page_data_o, 16'h1234)
		pm.pulse(2);
		wait_ready();
		`CHECK(n_fw, fw + 1)
		$display("test page done");
	endtask : t_page

	task automatic t_erase(input int exp_ee, input logic [7:0] hi);
		int ef = n_ef;
		int ee = n_ee;
		logic [7:0] v;
		op(CMD_CHIP_ERASE, 1'b0, 8'hFF);
		`CHECK(n_ef, ef + 1)
		`CHECK(n_ee, ee + exp_ee)
		rd(CMD_RD_FUSE, 1'b1, 1'b0, v);
		`CHECK(v, hi)
		$display("test erase done");
	endtask : t_erase

	task automatic t_fuse;
		logic [7:0] v;
		op(CMD_WR_FUSE, 1'b1, 8'hB1);
		`CHECK(eeprom_retain_fuse_o, 1'b0)
		`CHECK(fuse_high_o, 8'h99)
		serial_mode_i = 1'b1;
		op(CMD_WR_FUSE, 1'b1, 8'h91);
		serial_mode_i = 1'b0;
		rd(CMD_RD_FUSE, 1'b1, 1'b0, v);
		`CHECK(v, 8'hB1)
		op(CMD_WR_FUSE, 1'b0, 8'hE0);
		rd(CMD_RD_FUSE, 1'b0, 1'b0, v);
		`CHECK(v, 8'hE0)
		mode(1'b0);
		`CHECK(fuse_high_o, 8'hB1)
		`CHECK(fuse_low_o, 8'hE0)
		mode(1'b1);
		$display("test fuse done");
	endtask : t_fuse

	task automatic t_lock;
		logic [7:0] v;
		op(CMD_WR_LOCK, 1'b0, 8'hFE);
		op(CMD_WR_FUSE, 1'b0, 8'hFF);
		rd(CMD_RD_FUSE, 1'b0, 1'b0, v);
		`CHECK(v, 8'hE0)
		rd(CMD_RD_FUSE, 1'b0, 1'b1, v);
		`CHECK(v, 8'hFE)
		op(CMD_WR_LOCK, 1'b0, 8'hFC);
		rd(CMD_RD_FLASH, 1'b1, 1'b0, v);
		`CHECK(v, 8'hFF)
		t_sig();
		$display("test lock done");
	endtask : t_lock

	task automatic t_mem;
		int ew = n_ew;
		logic [7:0] v;
		flash_rdata = 16'hC3A9;
		eeprom_rdata = 8'h6D;
		rd(CMD_RD_FLASH, 1'b0, 1'b0, v);
		`CHECK(v, 8'hA9)
		rd(CMD_RD_FLASH, 1'b1, 1'b0, v);
		`CHECK(v, 8'hC3)
		rd(CMD_RD_EEPROM, 1'b0, 1'b0, v);
		`CHECK(v, 8'h6D)
		op(CMD_WR_EEPROM, 1'b0, 8'h42);
		`CHECK(n_ew, ew + 1)
		$display("test memory done");
	endtask : t_mem

	initial begin
		pm.step(2);
		rstn_i = 1'b1;
		pm.step(3);
		t_reset();
		mode(1'b1);
		t_sig();
		t_page();
		t_erase(1, 8'h99);
		t_fuse();
		t_erase(0, 8'hB1);
		t_mem();
		t_lock();
		end_sim();
	end

	// about fourteen times the expected run length
	initial begin
		#800000;
		fail_count++;
		$display("mismatch at %0t: watchdog expired", $time);
		end_sim();
	end
endmodule : fuse_config_and_parallel_prog_port_test
`default_nettype wire

// ===== fuse_prog_pkg.sv
/*
 * constants for the fuse store and parallel programming front end:
 * fuse bit positions, defaults, commands, action codes, page geometry.
 * assumes nothing beyond a SystemVerilog compiler.
 */
package fuse_prog_pkg;

	// ----------------------------------------
	// fuse high byte bit positions
	// ----------------------------------------
	localparam int HI_DEBUG_EN_BIT      = 7;
	localparam int HI_SCAN_EN_BIT       = 6;
	localparam int HI_SERIAL_EN_BIT     = 5;
	localparam int HI_OSC_OPT_BIT       = 4;
	localparam int HI_EE_RETAIN_BIT     = 3;
	localparam int HI_BOOT_HI_BIT       = 2;
	localparam int HI_BOOT_LO_BIT       = 1;
	localparam int HI_RST_VEC_BIT       = 0;

	// ----------------------------------------
	// fuse low byte bit positions
	// ----------------------------------------
	localparam int LO_BOD_LEVEL_BIT     = 7;
	localparam int LO_BOD_EN_BIT        = 6;
	localparam int LO_SUT_HI_BIT        = 5;
	localparam int LO_SUT_LO_BIT        = 4;
	localparam int LO_CKSEL_MSB         = 3;

	// ----------------------------------------
	// defaults, 1 = unprogrammed, 0 = programmed
	// ----------------------------------------
	localparam logic [7:0] FUSE_HI_DEFAULT = 8'h99;
	localparam logic [7:0] FUSE_LO_DEFAULT = 8'hE1;
	localparam logic [7:0] LOCK_DEFAULT    = 8'hFF;
	localparam int         LOCK_ONE_BIT    = 0;

	// ----------------------------------------
	// signature row, values arbitrary
	// ----------------------------------------
	localparam logic [7:0] SIG_BYTE0 = 8'hA5;
	localparam logic [7:0] SIG_BYTE1 = 8'h5A;
	localparam logic [7:0] SIG_BYTE2 = 8'h3C;
	localparam logic [7:0] CAL_1MHZ  = 8'h80;
	localparam logic [7:0] CAL_2MHZ  = 8'h81;
	localparam logic [7:0] CAL_4MHZ  = 8'h82;
	localparam logic [7:0] CAL_8MHZ  = 8'h83;

	// ----------------------------------------
	// action select and commands
	// ----------------------------------------
	localparam logic [1:0] ACT_ADDR = 2'h0;
	localparam logic [1:0] ACT_DATA = 2'h1;
	localparam logic [1:0] ACT_CMD  = 2'h2;
	localparam logic [1:0] ACT_IDLE = 2'h3;

	localparam logic [7:0] CMD_CHIP_ERASE = 8'h80;
	localparam logic [7:0] CMD_WR_FUSE    = 8'h40;
	localparam logic [7:0] CMD_WR_LOCK    = 8'h20;
	localparam logic [7:0] CMD_WR_FLASH   = 8'h10;
	localparam logic [7:0] CMD_WR_EEPROM  = 8'h11;
	localparam logic [7:0] CMD_RD_SIG     = 8'h08;
	localparam logic [7:0] CMD_RD_FUSE    = 8'h04;
	localparam logic [7:0] CMD_RD_FLASH   = 8'h02;
	localparam logic [7:0] CMD_RD_EEPROM  = 8'h03;
	localparam logic [7:0] CMD_NOP        = 8'h00;

	// ----------------------------------------
	// page geometry
	// ----------------------------------------
	localparam int FLASH_WORD_BITS = 7;
	localparam int FLASH_PAGE_BITS = 9;
	localparam int EE_BYTE_BITS    = 3;
	localparam int EE_PAGE_BITS    = 9;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS   = 40;
	localparam int STROBE_MIN_NS   = 250;
	localparam int STROBE_CYCLES   = (STROBE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int BUSY_CYCLES     = 16;

endpackage : fuse_prog_pkg

// ===== fuse_prog_port.sv
/*
 * fuse store with latched copies, signature row, calibration load and the
 * parallel programming pin front end (strobes, command, address, data bus).
 * assumes strobes from an external programmer, sampled on clock_i.
 */
`timescale 1ns/1ps
`default_nettype none
module fuse_prog_port
	import fuse_prog_pkg::*;
(
	input  wire logic        clock_i,
	input  wire logic        rstn_i,
	input  wire logic        prog_mode_i,
	input  wire logic        serial_mode_i,
	input  wire logic        prog_clock_pin_i,
	input  wire logic        action_select_0_i,
	input  wire logic        action_select_1_i,
	input  wire logic        byte_select_first_i,
	input  wire logic        byte_select_second_i,
	input  wire logic        page_load_strobe_i,
	input  wire logic        write_n_i,
	input  wire logic        output_enable_n_i,
	input  wire logic [7:0]  data_i,
	input  wire logic [15:0] flash_rdata_i,
	input  wire logic [7:0]  eeprom_rdata_i,
	output var  logic [7:0]  data_o,
	output var  logic        data_oe_o,
	output var  logic        ready_busy_out_o,
	output var  logic [7:0]  fuse_high_o,
	output var  logic [7:0]  fuse_low_o,
	output var  logic        eeprom_retain_fuse_o,
	output var  logic [7:0]  osc_calibration_reg_o,
	output var  logic        erase_flash_o,
	output var  logic        erase_eeprom_o,
	output var  logic        flash_page_write_o,
	output var  logic        eeprom_page_write_o,
	output var  logic        page_latch_o,
	output var  logic [15:0] word_addr_o,
	output var  logic [15:0] page_data_o
);
	typedef enum logic [1:0] {
		ST_OFF  = 2'b00,
		ST_IDLE = 2'b01,
		ST_BUSY = 2'b10
	} mode_e;

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	logic [7:0] pins_s;
	logic [7:0] data_s;
	// reset value equals the idle pins, so no false edge follows reset
	pin_sync #(.W(8), .INIT(8'h00)) u_pins (
		.clock_i (clock_i),
		.rstn_i  (rstn_i),
		.d_i     ({prog_mode_i, serial_mode_i, prog_clock_pin_i, action_select_1_i,
			action_select_0_i, byte_select_first_i, byte_select_second_i,
			page_load_strobe_i}),
		.q_o     (pins_s)
	);
	pin_sync #(.W(8), .INIT(8'h00)) u_data (
		.clock_i (clock_i),
		.rstn_i  (rstn_i),
		.d_i     (data_i),
		.q_o     (data_s)
	);
	logic [1:0] strobe_s;
	pin_sync #(.W(2), .INIT(2'h3)) u_strb (
		.clock_i (clock_i),
		.rstn_i  (rstn_i),
		.d_i     ({write_n_i, output_enable_n_i}),
		.q_o     (strobe_s)
	);

	logic prog_s, serial_s, xclk_s, bs1_s, bs2_s, page_load_strobe_s, wr_n_s, oe_n_s;
	logic [1:0] act_s;
	assign prog_s   = pins_s[7];
	assign serial_s = pins_s[6];
	assign xclk_s   = pins_s[5];
	assign act_s    = pins_s[4:3];
	assign bs1_s    = pins_s[2];
	assign bs2_s    = pins_s[1];
	assign page_load_strobe_s  = pins_s[0];
	assign wr_n_s   = strobe_s[1];
	assign oe_n_s   = strobe_s[0];

	// ----------------------------------------
	// state
	// ----------------------------------------
	mode_e       mode_reg, mode_next;
	logic        xclk_reg, page_load_strobe_reg, wr_n_reg, boot_reg;
	logic        xclk_next, page_load_strobe_next, wr_n_next, boot_next;
	logic [7:0]  cmd_reg, cmd_next, addr_lo_reg, addr_lo_next, addr_hi_reg, addr_hi_next;
	logic [7:0]  dat_lo_reg, dat_lo_next, dat_hi_reg, dat_hi_next;
	logic [7:0]  fhi_reg, fhi_next, flo_reg, flo_next, lock_reg, lock_next;
	logic [7:0]  fhi_act_reg, fhi_act_next, flo_act_reg, flo_act_next;
	logic [7:0]  cal_reg, cal_next, rd_reg, rd_next;
	logic        oe_reg, oe_next, rdy_reg, rdy_next, retain_reg, retain_next;
	logic        erf_reg, erf_next, ere_reg, ere_next, fpw_reg, fpw_next;
	logic        epw_reg, epw_next, latch_reg, latch_next;
	logic [15:0] wa_reg, wa_next, pd_reg, pd_next;
	logic [$clog2(BUSY_CYCLES+1)-1:0] cnt_reg, cnt_next;

	logic [7:0] sig_byte, cal_byte;
	always_comb begin
		case (addr_lo_reg[1:0])
			2'h0: sig_byte = SIG_BYTE0;
			2'h1: sig_byte = SIG_BYTE1;
			default: sig_byte = SIG_BYTE2;
		endcase
		case (addr_lo_reg[1:0])
			2'h0: cal_byte = CAL_1MHZ;
			2'h1: cal_byte = CAL_2MHZ;
			2'h2: cal_byte = CAL_4MHZ;
			default: cal_byte = CAL_8MHZ;
		endcase
	end

	logic xclk_rise, page_load_strobe_rise, wr_fall, locked;
	assign xclk_rise  = xclk_s & ~xclk_reg;
	assign page_load_strobe_rise = page_load_strobe_s & ~page_load_strobe_reg;
	assign wr_fall    = ~wr_n_s & wr_n_reg;
	assign locked     = ~lock_reg[LOCK_ONE_BIT];

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		mode_next    = mode_reg;
		xclk_next    = xclk_s;
		page_load_strobe_next   = page_load_strobe_s;
		wr_n_next    = wr_n_s;
		boot_next    = 1'b1;
		cmd_next     = cmd_reg;
		addr_lo_next = addr_lo_reg;
		addr_hi_next = addr_hi_reg;
		dat_lo_next  = dat_lo_reg;
		dat_hi_next  = dat_hi_reg;
		fhi_next     = fhi_reg;
		flo_next     = flo_reg;
		lock_next    = lock_reg;
		fhi_act_next = fhi_act_reg;
		flo_act_next = flo_act_reg;
		cal_next     = cal_reg;
		retain_next  = retain_reg;
		rdy_next     = rdy_reg;
		cnt_next     = cnt_reg;
		erf_next     = 1'b0;
		ere_next     = 1'b0;
		fpw_next     = 1'b0;
		epw_next     = 1'b0;
		latch_next   = 1'b0;
		wa_next      = {addr_hi_reg, addr_lo_reg};
		pd_next      = {dat_hi_reg, dat_lo_reg};
		// power-up latch of fuses and calibration
		if (!boot_reg) begin
			fhi_act_next = fhi_reg;
			flo_act_next = flo_reg;
			cal_next     = CAL_1MHZ;
		end
		case (mode_reg)
			ST_OFF: begin
				// entry needs page load strobe, action select and bs1 parked low
				if (prog_s && !page_load_strobe_s && act_s == ACT_ADDR && !bs1_s) begin
					mode_next    = ST_IDLE;
					fhi_act_next = fhi_reg;
					flo_act_next = flo_reg;
					cmd_next     = CMD_NOP;
				end
			end
			ST_IDLE: begin
				if (!prog_s) begin
					mode_next    = ST_OFF;
					fhi_act_next = fhi_reg;
					flo_act_next = flo_reg;
				end else if (xclk_rise) begin
					case (act_s)
						ACT_ADDR: begin
							if (bs1_s) addr_hi_next = data_s;
							else addr_lo_next = data_s;
						end
						ACT_DATA: begin
							if (bs1_s) dat_hi_next = data_s;
							else dat_lo_next = data_s;
						end
						ACT_CMD: cmd_next = data_s;
						default: ;
					endcase
				end else if (page_load_strobe_rise) begin
					latch_next = 1'b1;
				end else if (wr_fall) begin
					mode_next = ST_BUSY;
					rdy_next  = 1'b0;
					cnt_next  = '0;
					case (cmd_reg)
						CMD_CHIP_ERASE: begin
							erf_next  = 1'b1;
							ere_next  = retain_reg;
							lock_next = LOCK_DEFAULT;
						end
						CMD_WR_FUSE: begin
							// fuses locked once lock bit one is programmed
							if (!locked && bs1_s) begin
								fhi_next = dat_lo_reg;
								// serial access never reaches its own enable bit
								if (serial_s) begin
									fhi_next[HI_SERIAL_EN_BIT] = fhi_reg[HI_SERIAL_EN_BIT];
								end
								retain_next = dat_lo_reg[HI_EE_RETAIN_BIT];
							end else if (!locked) begin
								flo_next = dat_lo_reg;
							end
						end
						CMD_WR_LOCK: lock_next = lock_reg & dat_lo_reg;
						CMD_WR_FLASH: fpw_next = ~locked;
						CMD_WR_EEPROM: epw_next = ~locked;
						default: begin
							mode_next = ST_IDLE;
							rdy_next  = 1'b1;
						end
					endcase
				end
			end
			ST_BUSY: begin
				cnt_next = cnt_reg + 1'b1;
				if (cnt_reg == ($clog2(BUSY_CYCLES+1))'(BUSY_CYCLES - 1)) begin
					mode_next = ST_IDLE;
					rdy_next  = 1'b1;
				end
			end
			default: mode_next = ST_OFF;
		endcase
	end

	// ----------------------------------------
	// read data mux, drive only with oe low
	// ----------------------------------------
	always_comb begin
		oe_next = (mode_reg != ST_OFF) && !oe_n_s;
		rd_next = 8'hFF;
		case (cmd_reg)
			CMD_RD_SIG: rd_next = bs1_s ? cal_byte : sig_byte;
			CMD_RD_FUSE: begin
				if (bs2_s) rd_next = bs1_s ? LOCK_DEFAULT : lock_reg;
				else rd_next = bs1_s ? fhi_reg : flo_reg;
			end
			CMD_RD_FLASH: rd_next = (locked && !lock_reg[1]) ? 8'hFF :
				(bs1_s ? flash_rdata_i[15:8] : flash_rdata_i[7:0]);
			CMD_RD_EEPROM: rd_next = (locked && !lock_reg[1]) ? 8'hFF : eeprom_rdata_i;
			default: rd_next = 8'hFF;
		endcase
	end

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			mode_reg    <= ST_OFF;
			xclk_reg    <= 1'b0;
			page_load_strobe_reg   <= 1'b0;
			wr_n_reg    <= 1'b1;
			boot_reg    <= 1'b0;
			cmd_reg     <= CMD_NOP;
			addr_lo_reg <= 8'h00;
			addr_hi_reg <= 8'h00;
			dat_lo_reg  <= 8'hFF;
			dat_hi_reg  <= 8'hFF;
			fhi_reg     <= FUSE_HI_DEFAULT;
			flo_reg     <= FUSE_LO_DEFAULT;
			lock_reg    <= LOCK_DEFAULT;
			fhi_act_reg <= FUSE_HI_DEFAULT;
			flo_act_reg <= FUSE_LO_DEFAULT;
			cal_reg     <= CAL_1MHZ;
			retain_reg  <= FUSE_HI_DEFAULT[HI_EE_RETAIN_BIT];
			rdy_reg     <= 1'b1;
			cnt_reg     <= '0;
			erf_reg     <= 1'b0;
			ere_reg     <= 1'b0;
			fpw_reg     <= 1'b0;
			epw_reg     <= 1'b0;
			latch_reg   <= 1'b0;
			wa_reg      <= 16'h0000;
			pd_reg      <= 16'hFFFF;
			oe_reg      <= 1'b0;
			rd_reg      <= 8'hFF;
		end else begin
			mode_reg    <= mode_next;
			xclk_reg    <= xclk_next;
			page_load_strobe_reg   <= page_load_strobe_next;
			wr_n_reg    <= wr_n_next;
			boot_reg    <= boot_next;
			cmd_reg     <= cmd_next;
			addr_lo_reg <= addr_lo_next;
			addr_hi_reg <= addr_hi_next;
			dat_lo_reg  <= dat_lo_next;
			dat_hi_reg  <= dat_hi_next;
			fhi_reg     <= fhi_next;
			flo_reg     <= flo_next;
			lock_reg    <= lock_next;
			fhi_act_reg <= fhi_act_next;
			flo_act_reg <= flo_act_next;
			cal_reg     <= cal_next;
			retain_reg  <= retain_next;
			rdy_reg     <= rdy_next;
			cnt_reg     <= cnt_next;
			erf_reg     <= erf_next;
			ere_reg     <= ere_next;
			fpw_reg     <= fpw_next;
			epw_reg     <= epw_next;
			latch_reg   <= latch_next;
			wa_reg      <= wa_next;
			pd_reg      <= pd_next;
			oe_reg      <= oe_next;
			rd_reg      <= rd_next;
		end
	end

	// ----------------------------------------
	// outputs, all straight from flops
	// ----------------------------------------
	assign data_o                = rd_reg;
	assign data_oe_o             = oe_reg;
	assign ready_busy_out_o      = rdy_reg;
	assign fuse_high_o           = fhi_act_reg;
	assign fuse_low_o            = flo_act_reg;
	assign eeprom_retain_fuse_o  = retain_reg;
	assign osc_calibration_reg_o = cal_reg;
	assign erase_flash_o         = erf_reg;
	assign erase_eeprom_o        = ere_reg;
	assign flash_page_write_o    = fpw_reg;
	assign eeprom_page_write_o   = epw_reg;
	assign page_latch_o          = latch_reg;
	assign word_addr_o           = wa_reg;
	assign page_data_o           = pd_reg;
endmodule : fuse_prog_port
`default_nettype wire

// ===== fuse_prog_port_asserts.sv
/* concurrent checks on the fuse store and programming port pins.
   assumes one clock and strobes held well past the sync delay. */
`timescale 1ns/1ps
`default_nettype none
module fuse_prog_port_asserts
	import fuse_prog_pkg::*;
(
	input  wire logic       clock_i,
	input  wire logic       rstn_i,
	input  wire logic       prog_mode_i,
	input  wire logic       write_n_i,
	input  wire logic       output_enable_n_i,
	input  wire logic       data_oe_o,
	input  wire logic       ready_busy_out_o,
	input  wire logic [7:0] fuse_high_o,
	input  wire logic [7:0] fuse_low_o,
	input  wire logic       eeprom_retain_fuse_o,
	input  wire logic [7:0] osc_calibration_reg_o,
	input  wire logic       erase_flash_o,
	input  wire logic       erase_eeprom_o
);
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (!rstn_i);

	chk_oe_cause: assert property (data_oe_o |-> !$past(output_enable_n_i, 3))
		else $error("bus driven without output enable");
	chk_oe_release: assert property (output_enable_n_i [*5] |-> !data_oe_o)
		else $error("bus not released");
	chk_busy_len: assert property ($fell(ready_busy_out_o) |->
		(!ready_busy_out_o [*8]) ##1 (!ready_busy_out_o [*8]) ##1 ready_busy_out_o)
		else $error("busy span wrong");
	chk_busy_cause: assert property ($fell(ready_busy_out_o) |-> !$past(write_n_i, 2))
		else $error("busy without write strobe");
	chk_erase_sync: assert property ((erase_flash_o || erase_eeprom_o) |->
		$fell(ready_busy_out_o))
		else $error("erase pulse not at busy start");
	chk_erase_retain: assert property (erase_eeprom_o |-> eeprom_retain_fuse_o)
		else $error("eeprom erased while retained");
	chk_pulse_one: assert property (erase_flash_o |=> !erase_flash_o)
		else $error("erase pulse too long");
	chk_fuse_stable: assert property (prog_mode_i [*6] |->
		$stable(fuse_high_o) && $stable(fuse_low_o))
		else $error("active fuses moved in mode");
	chk_cal_value: assert property (osc_calibration_reg_o == CAL_1MHZ)
		else $error("calibration not the 1MHz value");
endmodule : fuse_prog_port_asserts

bind fuse_prog_port fuse_prog_port_asserts u_chk (
	.clock_i, .rstn_i, .prog_mode_i, .write_n_i, .output_enable_n_i,
	.data_oe_o, .ready_busy_out_o, .fuse_high_o, .fuse_low_o,
	.eeprom_retain_fuse_o, .osc_calibration_reg_o, .erase_flash_o, .erase_eeprom_o
);
`default_nettype wire

// ===== pin_sync.sv
/*
 * two-flop synchroniser for a bundle of pin inputs.
 * assumes one clock; reset value is passed as a constant parameter.
 */
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
	parameter int          W    = 1,
	parameter logic [W-1:0] INIT = '0
) (
	input  wire logic         clock_i,
	input  wire logic         rstn_i,
	input  wire logic [W-1:0] d_i,
	output var  logic [W-1:0] q_o
);
	logic [W-1:0] meta_reg;

	// ----------------------------------------
	// first flop feeds only the second
	// ----------------------------------------
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			meta_reg <= INIT;
			q_o      <= INIT;
		end else begin
			meta_reg <= d_i;
			q_o      <= meta_reg;
		end
	end
endmodule : pin_sync
`default_nettype wire

// ===== prog_model.sv
/* parallel programmer model: strobes, action codes, data bus.
   assumes the device answers on data_o while data_oe_o is high. */
`timescale 1ns/1ps
`default_nettype none
module prog_model
	import fuse_prog_pkg::*;
(
	input  wire logic       clock_i,
	input  wire logic [7:0] data_o,
	input  wire logic       data_oe_o,
	output var  logic       clk_pin_o,
	output var  logic [1:0] act_o,
	output var  logic       bs1_o,
	output var  logic       bs2_o,
	output var  logic       page_load_strobe_o,
	output var  logic       wr_n_o,
	output var  logic       oe_n_o,
	output var  logic [7:0] bus_o
);
	logic [7:0] drive_reg = 8'h00;
	logic       own_reg = 1'b0;
	// nobody driving: inverse of last value, never a stale copy
	assign bus_o = data_oe_o ? data_o : (own_reg ? drive_reg : ~drive_reg);

	initial begin
		clk_pin_o = 1'b0;
		act_o = ACT_ADDR;
		bs1_o = 1'b0;
		bs2_o = 1'b0;
		page_load_strobe_o = 1'b0;
		wr_n_o = 1'b1;
		oe_n_o = 1'b1;
	end

	task automatic step(input int n);
		repeat (n) @(posedge clock_i);
		#1;
	endtask : step

	// k: 0 clock pin, 1 page load, 2 write; held just above the minimum
	task automatic pulse(input int k);
		clk_pin_o = (k == 0);
		page_load_strobe_o = (k == 1);
		wr_n_o = (k != 2);
		step(STROBE_CYCLES);
		clk_pin_o = 1'b0;
		page_load_strobe_o = 1'b0;
		wr_n_o = 1'b1;
		step(STROBE_CYCLES);
	endtask : pulse

	task automatic load(input logic [1:0] act, input logic b1, input logic [7:0] v);
		act_o = act;
		bs1_o = b1;
		drive_reg = v;
		own_reg = 1'b1;
		step(1);
		pulse(0);
		own_reg = 1'b0;
		act_o = ACT_ADDR;
		bs1_o = 1'b0;
	endtask : load

	task automatic select(input logic b1);
		bs1_o = b1;
		step(1);
	endtask : select

	task automatic read(input logic b1, input logic b2, output logic [7:0] v);
		bs1_o = b1;
		bs2_o = b2;
		step(1);
		oe_n_o = 1'b0;
		step(STROBE_CYCLES);
		v = bus_o;
		oe_n_o = 1'b1;
		bs1_o = 1'b0;
		bs2_o = 1'b0;
		step(STROBE_CYCLES);
	endtask : read
endmodule : prog_model
`default_nettype wire
